// >>> inc/lmx_pkg.sv
`default_nettype none
package lmx_pkg;

  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;

  // Instruction group handled by this datapath
  typedef enum logic [3:0] {
    idle_op = 4'h0,
    load_immediate_op = 4'h1,
    or_immediate_op = 4'h2,
    or_register_op = 4'h3,
    store_accumulator_op = 4'h4,
    copy_reg_op = 4'h5,
    rotate_left_op = 4'h6,
    interrupt_return_op = 4'h7,
    return_immediate_op = 4'h8
  } lmx_op_e;

  // Gray coded: idle -> read -> idle, idle -> ret -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_RET = 2'b10
  } lmx_state_e;

  // Wishbone register byte offsets
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;

  // Status register bit positions
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_ZERO_BIT = 1;
  localparam int STAT_IRQ_ALLOW_BIT = 2;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic CARRY_RST = 1'b0;
  localparam logic ZERO_RST = 1'b0;
  localparam logic IRQ_ALLOW_RST = 1'b0;

  // Cycles taken by the return operations
  localparam int RET_CYCLES = 2;

endpackage

`default_nettype wire

// >>> core/lmx_alu.sv
`timescale 1ns/100ps
`default_nettype none

module lmx_alu (
  input wire lmx_pkg::lmx_op_e op, // Operation being executed
  input wire logic [7:0] acc, // Accumulator value
  input wire logic [7:0] operand, // Immediate or file register value
  input wire logic carry_in, // Current carry flag
  output logic [7:0] result, // Operation result
  output logic carry_out, // Carry after the operation
  output logic zero_out // Result equals zero
);

  always_comb
  begin
    carry_out = carry_in;
    case (op)
      lmx_pkg::or_immediate_op,
      lmx_pkg::or_register_op:
      begin
        result = acc | operand;
      end
      lmx_pkg::rotate_left_op:
      begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      lmx_pkg::store_accumulator_op:
      begin
        result = acc;
      end
      default:
      begin
        result = operand;
      end
    endcase
    zero_out = (result == 8'h00);
  end

endmodule

`default_nettype wire

// >>> core/lmx_exec.sv
// How it works
// - OR-immediate ORs accumulator with immediate, result to accumulator, updates zero.
// - Load-immediate puts immediate in accumulator, flags untouched.
// - OR-register ORs accumulator with file register, to destination, updates zero.
// - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// - Store copies accumulator into addressed file register, flags untouched.
// - Register copy moves file register to destination and updates zero.
// - Interrupt return loads program counter from stack top, sets interrupt allow.
// - Rotate-left shifts register left through carry, to destination, only carry changes.
// - Return-immediate loads accumulator and program counter, two cycles, no flags.
`timescale 1ns/100ps
`default_nettype none

module lmx_exec #(
  parameter int PC_W = lmx_pkg::PC_W
) (
  input wire logic clk, // 25 MHz core clock
  input wire logic rst_n, // Asynchronous reset
  input wire logic op_valid, // Decoder offers an operation
  input wire lmx_pkg::lmx_op_e op_code, // Operation code
  input wire logic [7:0] op_imm, // 8-bit immediate
  input wire logic [6:0] op_addr, // File register address
  input wire logic op_dest, // 0 accumulator, 1 file register
  output logic op_ready, // Operation can be taken
  output logic op_done, // Operation finished, one cycle
  output logic [6:0] file_addr, // File register address
  output logic [7:0] file_wdata, // File register write data
  output logic file_we, // File register write strobe
  input wire logic [7:0] file_rdata, // Data of file_addr
  output logic stack_pop, // Pop the return stack
  input wire logic [PC_W-1:0] stack_top, // Top of return stack
  output logic [PC_W-1:0] pc, // Program counter
  output logic pc_load, // Program counter reloaded
  output logic [7:0] acc, // Accumulator
  output logic carry, // Carry flag
  output logic zero, // Zero flag
  output logic global_irq_allow, // Global interrupt enable
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);

  lmx_pkg::lmx_state_e state_q, state_d;
  lmx_pkg::lmx_op_e op_q, alu_op;
  logic [7:0] imm_q;
  logic dest_q;
  logic op_ready_q, op_done_q;
  logic [6:0] file_addr_q;
  logic [7:0] file_wdata_q;
  logic file_we_q, stack_pop_q, pc_load_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] acc_q;
  logic carry_q, zero_q, irq_allow_q;
  logic [31:0] wb_dat_q;
  logic wb_ack_q;
  logic take, is_reg, is_ret, imm_ev, reg_ev, ret_ev;
  logic [7:0] alu_operand, alu_res;
  logic alu_carry, alu_zero;
  logic wb_wr, wb_wr_acc, wb_wr_stat;

  assign take = op_valid && op_ready_q;
  assign is_reg = (op_code == lmx_pkg::or_register_op) ||
                  (op_code == lmx_pkg::copy_reg_op) ||
                  (op_code == lmx_pkg::rotate_left_op);
  assign is_ret = (op_code == lmx_pkg::interrupt_return_op) ||
                  (op_code == lmx_pkg::return_immediate_op);
  assign imm_ev = take && ((op_code == lmx_pkg::or_immediate_op) ||
                           (op_code == lmx_pkg::load_immediate_op));
  assign reg_ev = (state_q == lmx_pkg::ST_READ);
  assign ret_ev = (state_q == lmx_pkg::ST_RET);

  // Immediates use the live decoder op; register ops use the latched one
  assign alu_op = reg_ev ? op_q : op_code;
  assign alu_operand = reg_ev ? file_rdata : op_imm;

  lmx_alu u_alu (
    .op(alu_op),
    .acc(acc_q),
    .operand(alu_operand),
    .carry_in(carry_q),
    .result(alu_res),
    .carry_out(alu_carry),
    .zero_out(alu_zero)
  );

  always_comb
  begin
    state_d = lmx_pkg::ST_IDLE;
    if (state_q == lmx_pkg::ST_IDLE && take)
    begin
      if (is_reg)
        state_d = lmx_pkg::ST_READ;
      else if (is_ret)
        state_d = lmx_pkg::ST_RET;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= lmx_pkg::ST_IDLE;
      op_ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_ready_q <= (state_d == lmx_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q <= lmx_pkg::idle_op;
      imm_q <= 8'h00;
      dest_q <= 1'b0;
    end
    else if (take)
    begin
      op_q <= op_code;
      imm_q <= op_imm;
      dest_q <= op_dest;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      op_done_q <= 1'b0;
    else
      op_done_q <= (take && !is_reg && !is_ret) || reg_ev || ret_ev;
  end

  // Datapath writes win over a software write in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_q <= lmx_pkg::ACC_RST;
    else if (imm_ev)
      acc_q <= alu_res;
    else if (reg_ev && !dest_q)
      acc_q <= alu_res;
    else if (ret_ev && op_q == lmx_pkg::return_immediate_op)
      acc_q <= imm_q;
    else if (wb_wr_acc)
      acc_q <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      zero_q <= lmx_pkg::ZERO_RST;
    else if ((imm_ev && op_code == lmx_pkg::or_immediate_op) ||
             (reg_ev && op_q != lmx_pkg::rotate_left_op))
      zero_q <= alu_zero;
    else if (wb_wr_stat)
      zero_q <= wb_dat_i[lmx_pkg::STAT_ZERO_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      carry_q <= lmx_pkg::CARRY_RST;
    else if (reg_ev && op_q == lmx_pkg::rotate_left_op)
      carry_q <= alu_carry;
    else if (wb_wr_stat)
      carry_q <= wb_dat_i[lmx_pkg::STAT_CARRY_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_allow_q <= lmx_pkg::IRQ_ALLOW_RST;
    else if (ret_ev && op_q == lmx_pkg::interrupt_return_op)
      irq_allow_q <= 1'b1;
    else if (wb_wr_stat)
      irq_allow_q <= wb_dat_i[lmx_pkg::STAT_IRQ_ALLOW_BIT];
  end

  // Address is held after a read so the register file stays quiet
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      file_addr_q <= 7'h00;
      file_wdata_q <= 8'h00;
      file_we_q <= 1'b0;
    end
    else
    begin
      file_we_q <= 1'b0;
      if (take && op_code == lmx_pkg::store_accumulator_op)
      begin
        file_addr_q <= op_addr;
        file_wdata_q <= acc_q;
        file_we_q <= 1'b1;
      end
      else if (take && is_reg)
        file_addr_q <= op_addr;
      else if (reg_ev && dest_q)
      begin
        file_wdata_q <= alu_res;
        file_we_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_pop_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_q <= PC_W'(lmx_pkg::PC_RST);
    end
    else
    begin
      stack_pop_q <= take && is_ret;
      pc_load_q <= ret_ev;
      if (ret_ev)
        pc_q <= stack_top;
    end
  end

  // Wishbone classic slave, one wait state, unmapped reads give zero
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_q && wb_sel_i[0];
  assign wb_wr_acc = wb_wr && (wb_adr_i == lmx_pkg::REG_ACC);
  assign wb_wr_stat = wb_wr && (wb_adr_i == lmx_pkg::REG_STATUS);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      wb_dat_q <= 32'h0000_0000;
      case (wb_adr_i)
        lmx_pkg::REG_ACC: wb_dat_q[7:0] <= acc_q;
        lmx_pkg::REG_STATUS: wb_dat_q[2:0] <= {irq_allow_q, zero_q, carry_q};
        lmx_pkg::REG_PC: wb_dat_q[PC_W-1:0] <= pc_q;
        default: wb_dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign op_ready = op_ready_q;
  assign op_done = op_done_q;
  assign file_addr = file_addr_q;
  assign file_wdata = file_wdata_q;
  assign file_we = file_we_q;
  assign stack_pop = stack_pop_q;
  assign pc = pc_q;
  assign pc_load = pc_load_q;
  assign acc = acc_q;
  assign carry = carry_q;
  assign zero = zero_q;
  assign global_irq_allow = irq_allow_q;
  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;

  // Checks
  logic [7:0] or_imm_res;
  logic take_or_imm, take_load, take_store, take_iret, take_rimm;
  assign or_imm_res = acc_q | op_imm;
  assign take_or_imm = take && op_code == lmx_pkg::or_immediate_op;
  assign take_load = take && op_code == lmx_pkg::load_immediate_op;
  assign take_store = take && op_code == lmx_pkg::store_accumulator_op;
  assign take_iret = take && op_code == lmx_pkg::interrupt_return_op;
  assign take_rimm = take && op_code == lmx_pkg::return_immediate_op;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_or_imm;
    take_or_imm |=> acc_q == $past(or_imm_res) &&
      zero_q == ($past(or_imm_res) == 8'h00);
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");
  property p_load_imm;
    take_load && !wb_wr_stat |=> acc_q == $past(op_imm) &&
      $stable(zero_q) && $stable(carry_q);
  endproperty
  a_load_imm: assert property (p_load_imm) else $error("load imm wrong");
  property p_or_reg;
    reg_ev && op_q == lmx_pkg::or_register_op && !dest_q |=>
      acc_q == ($past(acc_q) | $past(file_rdata));
  endproperty
  a_or_reg: assert property (p_or_reg) else $error("or register wrong");
  property p_dest_file;
    reg_ev && dest_q && !wb_wr_acc |=>
      file_we_q && $stable(file_addr_q) && $stable(acc_q);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest bad");
  property p_store;
    take_store && !wb_wr_stat |=> file_we_q && file_wdata_q == $past(acc_q) &&
      file_addr_q == $past(op_addr) && $stable(zero_q);
  endproperty
  a_store: assert property (p_store) else $error("store wrong");
  property p_copy_zero;
    reg_ev && op_q == lmx_pkg::copy_reg_op |=>
      zero_q == ($past(file_rdata) == 8'h00);
  endproperty
  a_copy_zero: assert property (p_copy_zero) else $error("copy zero");
  sequence s_pop_then_load;
    stack_pop_q ##1 (pc_load_q && pc_q == $past(stack_top));
  endsequence
  property p_iret;
    take_iret |=> s_pop_then_load ##0 (irq_allow_q && op_done_q);
  endproperty
  a_iret: assert property (p_iret) else $error("interrupt return");
  property p_rotl;
    reg_ev && op_q == lmx_pkg::rotate_left_op && !wb_wr_stat |=>
      carry_q == $past(file_rdata[7]) && $stable(zero_q);
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate wrong");
  property p_rimm;
    take_rimm |=> (!op_done_q && !op_ready_q) ##1
      (op_done_q && acc_q == $past(op_imm, 2) && pc_load_q);
  endproperty
  a_rimm: assert property (p_rimm) else $error("return imm wrong");
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_q |=> wb_ack_q ##1 !wb_ack_q;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack");

endmodule

`default_nettype wire

// >>> sim/lmx_partner.sv
`timescale 1ns/100ps
`default_nettype none

module lmx_partner #(
  parameter int PC_W = 13
) (
  input wire logic clk, // Core clock
  input wire logic [6:0] file_addr, // Read and write address
  input wire logic [7:0] file_wdata, // Write data
  input wire logic file_we, // Write strobe
  output logic [7:0] file_rdata, // Asynchronous read data
  input wire logic stack_pop, // Pop request
  output logic [PC_W-1:0] stack_top // Return address
);
  logic [7:0] mem [128];
  logic [2:0] sp_q = 3'h6;
  logic [PC_W-1:0] top_t;

  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
  end

  always @(posedge clk)
  begin
    if (file_we)
    begin
      mem[file_addr] <= file_wdata;
    end
    if (stack_pop)
    begin
      sp_q <= sp_q - 3'h1;
    end
  end

  assign top_t = PC_W'({sp_q, 10'h155});
  assign file_rdata = mem[file_addr];
  // Inverted outside the pop window so a late sample cannot pass
  assign stack_top = stack_pop ? top_t : ~top_t;
endmodule

`default_nettype wire

// >>> sim/literal_logic_move_return_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none

module literal_logic_move_return_exec_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  lmx_pkg::lmx_op_e op_code = lmx_pkg::idle_op;
  logic [7:0] op_imm = 8'h00;
  logic [6:0] op_addr = 7'h00;
  logic op_dest = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic op_ready, op_done, file_we, stack_pop, pc_load, wb_ack_o;
  logic carry, zero, global_irq_allow;
  logic [6:0] file_addr;
  logic [7:0] file_wdata, file_rdata, acc;
  logic [12:0] stack_top, pc;
  logic [31:0] wb_dat_o, q;
  int err_count = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;

  always #20 clk = ~clk;

  lmx_exec dut_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .op_addr(op_addr),
    .op_dest(op_dest), .op_ready(op_ready), .op_done(op_done),
    .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .file_rdata(file_rdata), .stack_pop(stack_pop),
    .stack_top(stack_top), .pc(pc), .pc_load(pc_load), .acc(acc),
    .carry(carry), .zero(zero), .global_irq_allow(global_irq_allow),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  lmx_partner p_u (.clk(clk), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .file_rdata(file_rdata),
    .stack_pop(stack_pop), .stack_top(stack_top));

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Latency is checked on every call, counted in cycles after the take
  task automatic do_op(input lmx_pkg::lmx_op_e c, input logic [7:0] k,
    input logic [6:0] a, input logic d, input int lat);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_imm <= k;
    op_addr <= a;
    op_dest <= d;
    do @(negedge clk); while (op_ready !== 1'b1 && ++n < 20);
    @(posedge clk);
    op_valid <= 1'b0;
    n = 0;
    do @(negedge clk); while (op_done !== 1'b1 && ++n < 8);
    chk(n + 1, lat);
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 8);
    chk(wb_ack_o, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  // A file write lands at the edge after the done cycle
  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(lmx_pkg::REG_ACC, 32'h0);
    rd(lmx_pkg::REG_STATUS, 32'h0);
    rd(lmx_pkg::REG_PC, 32'h0);
    wb(1'b1, 8'h10, 8'h5a);
    rd(8'h10, 32'h0);
    wb(1'b1, lmx_pkg::REG_STATUS, 8'h03);
    do_op(lmx_pkg::load_immediate_op, 8'h5a, 7'h00, 1'b0, 1);
    chk({acc, carry, zero}, {8'h5a, 2'h3});
    do_op(lmx_pkg::or_immediate_op, 8'h81, 7'h00, 1'b0, 1);
    chk({acc, carry, zero}, {8'h5a | 8'h81, 2'h2});
    do_op(lmx_pkg::load_immediate_op, 8'h00, 7'h00, 1'b0, 1);
    do_op(lmx_pkg::or_immediate_op, 8'h00, 7'h00, 1'b0, 1);
    chk({acc, zero}, {8'h00, 1'b1});
    do_op(lmx_pkg::load_immediate_op, 8'h24, 7'h00, 1'b0, 1);
    do_op(lmx_pkg::store_accumulator_op, 8'h00, 7'h10, 1'b0, 1);
    settle();
    chk({p_u.mem[16], carry, zero}, {8'h24, 2'h3});
    do_op(lmx_pkg::load_immediate_op, 8'h42, 7'h00, 1'b0, 1);
    do_op(lmx_pkg::or_register_op, 8'h00, 7'h10, 1'b0, 2);
    chk({acc, zero, p_u.mem[16]}, {8'h66, 1'b0, 8'h24});
    do_op(lmx_pkg::or_register_op, 8'h00, 7'h10, 1'b1, 2);
    settle();
    chk({acc, p_u.mem[16]}, {8'h66, 8'h66});
    do_op(lmx_pkg::copy_reg_op, 8'h00, 7'h3c, 1'b1, 2);
    settle();
    chk({acc, zero, p_u.mem[60]}, {8'h66, 1'b1, 8'h00});
    do_op(lmx_pkg::copy_reg_op, 8'h00, 7'h11, 1'b0, 2);
    chk({acc, zero}, {8'h11 ^ 8'h3c, 1'b0});
    do_op(lmx_pkg::rotate_left_op, 8'h00, 7'h10, 1'b0, 2);
    chk({acc, carry, zero}, {8'hcd, 2'h0});
    do_op(lmx_pkg::store_accumulator_op, 8'h00, 7'h20, 1'b0, 1);
    do_op(lmx_pkg::rotate_left_op, 8'h00, 7'h20, 1'b1, 2);
    settle();
    chk({acc, carry, zero, p_u.mem[32]}, {8'hcd, 2'h2, 8'h9a});
    do_op(lmx_pkg::return_immediate_op, 8'h99, 7'h00, 1'b0, 2);
    chk({acc, carry, zero, pc, pc_load},
      {8'h99, 2'h2, 3'h6, 10'h155, 1'b1});
    do_op(lmx_pkg::interrupt_return_op, 8'h00, 7'h00, 1'b0, 2);
    chk({global_irq_allow, pc, acc}, {1'b1, 3'h5, 10'h155, 8'h99});
    rd(lmx_pkg::REG_STATUS, 32'h5);
    do_op(lmx_pkg::idle_op, 8'hff, 7'h20, 1'b1, 1);
    rd(lmx_pkg::REG_ACC, 32'h99);
    rd(lmx_pkg::REG_PC, {19'h0, 3'h5, 10'h155});
    print_verdict();
  end
endmodule

`default_nettype wire
